// ==== fpuc_ctrl.v ====
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "fpuc_map.vh"
// Function
// - 16-bit kHz clock value from two bytes
// - readout option blocks debug reads of code
// - write option 0 blocks user program/erase
// - write option 1 permits, subject to locks
// - reset enters locked state
// - page mismatch relocks, match activates page
// - 95H erases active unprotected page
// - unknown control value relocks
// - mass erase only from debug port
// - unlocked page accepts repeated byte writes
// - up to eight sectors, at least one page each
// - protected sector rejects program and erase
// - sector mask clears on reset
// - 5EH steers next page write to mask
// - mask bits are set-only
module fpuc_ctrl #(
  parameter AW = 10,
  parameter PAGE_AW = 9,
  parameter CLK_KHZ = 100000
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire [AW-1:0] user_addr_i,
  input wire dbg_access_i,
  input wire readout_protect_option_i,
  input wire write_protect_option_i,
  output wire busy_o,
  output wire unlocked_o
);
  localparam PW = AW - PAGE_AW;
  localparam SECT_AW = (PAGE_AW > AW - 3) ? PAGE_AW : AW - 3;
  localparam [2:0] S_LOCK = 3'd0;
  localparam [2:0] S_PAGE1 = 3'd1;
  localparam [2:0] S_KEY1 = 3'd2;
  localparam [2:0] S_KEY2 = 3'd3;
  localparam [2:0] S_OPEN = 3'd4;
  // cells cleared by one page erase and by a mass erase
  localparam [AW:0] PAGE_BYTES = {{(AW-PAGE_AW){1'b0}}, 1'b1,
                                  {PAGE_AW{1'b0}}};
  localparam [AW:0] ARRAY_BYTES = {1'b1, {AW{1'b0}}};

  // ---------------------------------------------------------------------------
  // bus handshake: writes wait while busy, reads wait one cycle
  // ---------------------------------------------------------------------------
  reg rd_done_q;
  wire busy_w;
  assign avs_waitrequest_o = (avs_read_i & ~rd_done_q) |
                             (avs_write_i & busy_w);
  wire wr_w = avs_write_i & ~busy_w;
  wire [7:0] wd_w = avs_writedata_i[7:0];
  wire wr_ctrl = wr_w & (avs_address_i == `FPUC_OFF_CTRL);
  wire wr_page = wr_w & (avs_address_i == `FPUC_OFF_PAGE);
  wire wr_data = wr_w & (avs_address_i == `FPUC_OFF_DATA);
  wire wr_dbg = wr_w & (avs_address_i == `FPUC_OFF_DBG);

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg [2:0] state_q;
  reg [PW-1:0] page_q;
  reg [PW-1:0] active_q;
  reg prot_sel_q;
  reg [7:0] sector_lock_mask_q;
  reg [15:0] flash_clock_khz_q;
  reg [31:0] timer_q;
  reg [AW:0] left_q;
  reg [AW-1:0] ptr_q;
  reg [AW-1:0] waddr_q;
  reg [7:0] wdata_q;
  reg mem_we_q;

  // busy covers both the paced time and the cell walk of an erase, so
  // no write request can slip in while cells are still being cleared
  assign busy_w = (timer_q != 32'd0) | (left_q != {(AW+1){1'b0}});
  assign busy_o = busy_w;
  assign unlocked_o = (state_q == S_OPEN);

  // sector of the active page and of the byte target
  wire [AW-1:0] act_base = {active_q, {PAGE_AW{1'b0}}};
  // the shift keeps the sector index three bits wide even when a sector
  // is a whole page and the page field is narrower than three bits
  wire [AW-1:0] act_shift = act_base >> SECT_AW;
  wire [2:0] act_sect = act_shift[2:0];
  wire [AW-1:0] data_addr = {active_q, avs_writedata_i[PAGE_AW+7:8]};
  wire [AW-1:0] data_shift = data_addr >> SECT_AW;
  wire [2:0] data_sect = data_shift[2:0];
  wire wp_ok = write_protect_option_i;
  wire act_free = ~sector_lock_mask_q[act_sect];
  wire data_free = ~sector_lock_mask_q[data_sect];
  wire data_page_hit =
    (avs_writedata_i[AW+7:PAGE_AW+8] == active_q) ||
    (avs_writedata_i[31] == 1'b0); // bit31 low: offset within active page

  // ---------------------------------------------------------------------------
  // unlock state machine
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_LOCK;
      page_q <= {PW{1'b0}};
      active_q <= {PW{1'b0}};
      prot_sel_q <= 1'b0;
      sector_lock_mask_q <= `FPUC_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        prot_sel_q <= (wd_w == `FPUC_CMD_PROT);
        case (state_q)
          S_PAGE1: begin
            state_q <= (wd_w == `FPUC_KEY1) ? S_KEY1 : S_LOCK;
          end
          S_KEY1: begin
            state_q <= (wd_w == `FPUC_KEY2) ? S_KEY2 : S_LOCK;
          end
          default: begin
            state_q <= S_LOCK;
          end
        endcase
      end else if (wr_page) begin
        prot_sel_q <= 1'b0;
        if (prot_sel_q) begin
          sector_lock_mask_q <= sector_lock_mask_q | wd_w;
        end else begin
          page_q <= wd_w[PW-1:0];
          if (state_q == S_KEY2) begin
            if (wd_w[PW-1:0] == page_q) begin
              state_q <= S_OPEN;
              active_q <= page_q;
            end else begin
              state_q <= S_LOCK;
            end
          end else begin
            state_q <= S_PAGE1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // program / erase sequencer paced by the kHz value
  // ---------------------------------------------------------------------------
  wire go_erase = wr_ctrl & (wd_w == `FPUC_CMD_ERASE) &
                  (state_q == S_OPEN) & wp_ok & act_free;
  wire go_prog = wr_data & (state_q == S_OPEN) & wp_ok & data_free &
                 data_page_hit;
  wire go_mass = wr_dbg & dbg_access_i & (wd_w == `FPUC_CMD_MASS) &
                 (sector_lock_mask_q == 8'h00);
  wire [31:0] khz32 = {16'h0000, flash_clock_khz_q};
  wire [31:0] prog_len = (`FPUC_PROG_US * khz32) / 32'd1000 + 32'd1;
  wire [31:0] erase_len = ((`FPUC_ERASE_US * khz32) << 10) / 32'd1000 +
                          32'd1;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_clock_khz_q <= `FPUC_RST_FREQ;
      timer_q <= 32'd0;
      left_q <= {(AW+1){1'b0}};
      ptr_q <= {AW{1'b0}};
      waddr_q <= {AW{1'b0}};
      wdata_q <= 8'h00;
      mem_we_q <= 1'b0;
    end else begin
      mem_we_q <= 1'b0;
      if (wr_w && avs_address_i == `FPUC_OFF_FREQ_HI) begin
        flash_clock_khz_q[15:8] <= wd_w;
      end
      if (wr_w && avs_address_i == `FPUC_OFF_FREQ_LO) begin
        flash_clock_khz_q[7:0] <= wd_w;
      end
      if (go_prog) begin
        timer_q <= prog_len;
        waddr_q <= data_addr;
        wdata_q <= avs_writedata_i[7:0];
        mem_we_q <= 1'b1;
      end else if (go_erase) begin
        timer_q <= erase_len;
        left_q <= PAGE_BYTES;
        ptr_q <= act_base;
      end else if (go_mass) begin
        timer_q <= erase_len;
        left_q <= ARRAY_BYTES;
        ptr_q <= {AW{1'b0}};
      end else begin
        if (timer_q != 32'd0) begin
          timer_q <= timer_q - 32'd1;
        end
        // one cell per clock, counted by size rather than by the timer,
        // so a fast clock value cannot spill into the next page
        if (left_q != {(AW+1){1'b0}}) begin
          waddr_q <= ptr_q;
          wdata_q <= 8'hFF;
          mem_we_q <= 1'b1;
          ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
          left_q <= left_q - {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // flash array and readback
  // ---------------------------------------------------------------------------
  wire [7:0] mem_rdata;
  fpuc_mem #(
    .AW(AW)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .we_i(mem_we_q),
    .addr_i(mem_we_q ? waddr_q : user_addr_i),
    .wdata_i(wdata_q),
    .rdata_o(mem_rdata)
  );

  wire [7:0] status_w;
  assign status_w = {2'b00, (state_q == S_KEY1 || state_q == S_KEY2),
                     readout_protect_option_i, write_protect_option_i,
                     prot_sel_q, busy_w, unlocked_o};

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done_q <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      rd_done_q <= avs_read_i & ~rd_done_q;
      if (avs_read_i && !rd_done_q) begin
        case (avs_address_i)
          `FPUC_OFF_PAGE: begin
            avs_readdata_o <= prot_sel_q ? {24'h000000, sector_lock_mask_q}
                              : {{(32-PW){1'b0}}, page_q};
          end
          `FPUC_OFF_FREQ_HI: begin
            avs_readdata_o <= {24'h000000, flash_clock_khz_q[15:8]};
          end
          `FPUC_OFF_FREQ_LO: begin
            avs_readdata_o <= {24'h000000, flash_clock_khz_q[7:0]};
          end
          `FPUC_OFF_STATUS: begin
            avs_readdata_o <= {24'h000000, status_w};
          end
          `FPUC_OFF_DATA: begin
            // debug reads see zero when readout protection is set
            avs_readdata_o <= (dbg_access_i && readout_protect_option_i) ?
                              32'h00000000 : {24'h000000, mem_rdata};
          end
          default: begin
            avs_readdata_o <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule // fpuc_ctrl

// ==== fpuc_map.vh ====
`ifndef FPUC_MAP_VH
`define FPUC_MAP_VH
// ---------------------------------------------------------------------------
// register byte offsets (avalon word addresses times four)
// ---------------------------------------------------------------------------
`define FPUC_OFF_CTRL 6'h00
`define FPUC_OFF_PAGE 6'h04
`define FPUC_OFF_FREQ_HI 6'h08
`define FPUC_OFF_FREQ_LO 6'h0C
`define FPUC_OFF_STATUS 6'h10
`define FPUC_OFF_DATA 6'h14
`define FPUC_OFF_DBG 6'h18
// ---------------------------------------------------------------------------
// control command values
// ---------------------------------------------------------------------------
`define FPUC_KEY1 8'h73
`define FPUC_KEY2 8'h8C
`define FPUC_CMD_ERASE 8'h95
`define FPUC_CMD_PROT 8'h5E
`define FPUC_CMD_MASS 8'h63
// ---------------------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------------------
`define FPUC_ST_UNLOCKED 0
`define FPUC_ST_BUSY 1
`define FPUC_ST_PROTSEL 2
`define FPUC_ST_WP 3
`define FPUC_ST_RP 4
`define FPUC_ST_KEY 5
// ---------------------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------------------
`define FPUC_RST_FREQ 16'h0000
`define FPUC_RST_MASK 8'h00
`define FPUC_MIN_KHZ 16'h0020
`define FPUC_MAX_KHZ 16'h4E20
`define FPUC_PROG_US 16'h0028
`define FPUC_ERASE_US 16'h000A
`endif

// ==== fpuc_mem.v ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// flash array model storage, registered read data
// ---------------------------------------------------------------------------
module fpuc_mem #(
  parameter AW = 10
) (
  input wire ref_clk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // fpuc_mem

// ==== fpuc_ctrl_monitor.sv ====
`timescale 1ns/1ps
`include "fpuc_map.vh"
module fpuc_ctrl_monitor #(
  parameter AW = 10,
  parameter PAGE_AW = 9,
  parameter CLK_KHZ = 100000
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [AW-1:0] user_addr_i,
  input wire dbg_access_i,
  input wire readout_protect_option_i,
  input wire write_protect_option_i,
  input wire busy_o,
  input wire unlocked_o
);
  wire wr_ok = avs_write_i && !avs_waitrequest_o;
  reg pg_wr_q;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pg_wr_q <= 1'b0;
    else pg_wr_q <= wr_ok && avs_address_i == `FPUC_OFF_PAGE;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_locked: assert property ($rose(rst_n_i) |-> !unlocked_o && !busy_o)
    else $error("not idle after reset");
  a_unlock_cause: assert property ($rose(unlocked_o) |-> pg_wr_q)
    else $error("unlock without page write");
  a_ctrl_relocks: assert property (wr_ok && avs_address_i == `FPUC_OFF_CTRL
    |=> !unlocked_o) else $error("control write left page open");
  a_wp_blocks: assert property ($rose(busy_o)
    |-> $past(write_protect_option_i) || $past(dbg_access_i)) else $error("wp");
  a_mass_refused: assert property (wr_ok && avs_address_i == `FPUC_OFF_DBG
    && !dbg_access_i && !busy_o |=> !busy_o) else $error("user mass erase");
  a_locked_ignored: assert property (wr_ok && !unlocked_o && !busy_o
    && avs_address_i == `FPUC_OFF_DATA |=> !busy_o [*2]) else $error("locked");
  a_busy_stalls: assert property (busy_o && avs_write_i |-> avs_waitrequest_o)
    else $error("write taken while busy");
  a_busy_cause: assert property ($rose(busy_o)
    |-> $past(unlocked_o) || $past(dbg_access_i)) else $error("busy while locked");
endmodule // fpuc_ctrl_monitor
bind fpuc_ctrl fpuc_ctrl_monitor #(
  .AW(AW),
  .PAGE_AW(PAGE_AW),
  .CLK_KHZ(CLK_KHZ)
) fpuc_ctrl_monitor_i (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .user_addr_i(user_addr_i),
  .dbg_access_i(dbg_access_i),
  .readout_protect_option_i(readout_protect_option_i),
  .write_protect_option_i(write_protect_option_i),
  .busy_o(busy_o),
  .unlocked_o(unlocked_o)
);

// ==== fpuc_flash_ref.sv ====
`timescale 1ns/1ps
module fpuc_flash_ref;
  reg [7:0] mem_q [0:1023];
  reg [7:0] lock_q = 8'h00;
  integer n;
  // eight 128-byte sectors of one page each, so the page picks the lock bit
  task clr;
    lock_q = 8'h00;
  endtask
  task prot(input [7:0] m);
    lock_q = lock_q | m;
  endtask
  task pgm(input [9:0] a, input [7:0] d, input w, input u);
    if (w && u && !lock_q[a[9:7]]) mem_q[a] = d;
  endtask
  // erased cells read all ones, the usual flash convention
  task ers(input [2:0] p, input w, input u);
    if (w && u && !lock_q[p])
      for (n = 0; n < 128; n = n + 1) mem_q[{p, n[6:0]}] = 8'hFF;
  endtask
endmodule // fpuc_flash_ref

// ==== flash_protect_unlock_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "fpuc_map.vh"
module flash_protect_unlock_ctrl_tb;
  reg ref_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  reg dbg_access_i = 1'b0, readout_protect_option_i = 1'b0, ul = 1'b0;
  reg write_protect_option_i = 1'b1;
  reg [5:0] avs_address_i = 6'h00;
  reg [31:0] avs_writedata_i = 32'h0, seed = 32'h6838, rd;
  reg [9:0] user_addr_i = 10'h000;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, busy_o, unlocked_o;
  integer mismatches = 0, checks = 0, cyc = 0, i, k;
  reg [2:0] pg;
  reg [6:0] off;
  reg [7:0] b;
  reg ex;
  always #5 ref_clk_i = ~ref_clk_i;
  fpuc_ctrl #(
    .AW(10),
    .PAGE_AW(7)
  ) fpuc_ctrl_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .user_addr_i(user_addr_i),
    .dbg_access_i(dbg_access_i),
    .readout_protect_option_i(readout_protect_option_i),
    .write_protect_option_i(write_protect_option_i),
    .busy_o(busy_o),
    .unlocked_o(unlocked_o)
  );
  fpuc_flash_ref fpuc_flash_ref_i ();
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  // waitrequest is looked at on the rising edge, before that edge's
  // register updates land, so it is the value the slave sampled
  task wr(input [5:0] a, input [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task rdr(input [5:0] a);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task settle;
    @(negedge ref_clk_i);
    while (busy_o !== 1'b0) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
  endtask
  task vfy(input [9:0] a);
    user_addr_i <= a;
    // the array read is registered, so the address leads the read a cycle
    @(posedge ref_clk_i);
    rdr(`FPUC_OFF_DATA);
    check(rd, {24'h0, fpuc_flash_ref_i.mem_q[a]});
  endtask
  task unlock(input [2:0] p, input [2:0] q);
    wr(`FPUC_OFF_PAGE, {29'h0, p});
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_KEY1});
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_KEY2});
    wr(`FPUC_OFF_PAGE, {29'h0, q});
    ul = (p == q);
    check(unlocked_o, ul);
  endtask
  task prog(input [6:0] o, input [7:0] d);
    wr(`FPUC_OFF_DATA, {17'h0, o, d});
    fpuc_flash_ref_i.pgm({pg, o}, d, write_protect_option_i, ul);
    settle;
    vfy({pg, o});
  endtask
  task erase;
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_CMD_ERASE});
    ex = write_protect_option_i & ul & ~fpuc_flash_ref_i.lock_q[pg];
    check(busy_o, ex);
    fpuc_flash_ref_i.ers(pg, write_protect_option_i, ul);
    ul = 1'b0;
    settle;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    check(unlocked_o, 0);
    wr(`FPUC_OFF_FREQ_HI, 32'h0);
    wr(`FPUC_OFF_FREQ_LO, 32'h20);
    rdr(`FPUC_OFF_FREQ_LO);
    check(rd, 32'h20);
    for (k = 0; k < 6; k = k + 1) begin
      seed = lfsr(seed);
      {pg, off, b} = seed[17:0];
      unlock(pg, pg);
      erase;
      vfy({pg, off});
      unlock(pg, pg);
      for (i = 0; i < 3; i = i + 1) prog(off + i[6:0], b ^ i[7:0]);
      // top bits set keeps the random value clear of every command
      wr(`FPUC_OFF_CTRL, {24'h0, 2'b11, seed[21:16]});
      ul = 1'b0;
      check(unlocked_o, 0);
      prog(off + 7'h03, b);
      unlock(pg, pg + 3'h1);
    end
    write_protect_option_i <= 1'b0;
    unlock(pg, pg);
    prog(off + 7'h04, 8'h5A);
    erase;
    vfy({pg, off});
    write_protect_option_i <= 1'b1;
    wr(`FPUC_OFF_DBG, {24'h0, `FPUC_CMD_MASS});
    settle;
    vfy({pg, off});
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_CMD_PROT});
    wr(`FPUC_OFF_PAGE, {24'h0, 8'h01 << pg});
    fpuc_flash_ref_i.prot(8'h01 << pg);
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_CMD_PROT});
    wr(`FPUC_OFF_PAGE, 32'h0);
    wr(`FPUC_OFF_CTRL, {24'h0, `FPUC_CMD_PROT});
    rdr(`FPUC_OFF_PAGE);
    check(rd, {24'h0, fpuc_flash_ref_i.lock_q});
    // any other control value drops the mask selection again
    wr(`FPUC_OFF_CTRL, {24'h0, 8'hC0});
    unlock(pg, pg);
    prog(off + 7'h05, 8'hA5);
    erase;
    vfy({pg, off});
    readout_protect_option_i <= 1'b1;
    dbg_access_i <= 1'b1;
    user_addr_i <= {pg, off};
    rdr(`FPUC_OFF_DATA);
    check(rd, 32'h00000000);
    dbg_access_i <= 1'b0;
    vfy({pg, off});
    readout_protect_option_i <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    fpuc_flash_ref_i.clr;
    check(unlocked_o, 0);
    unlock(pg, pg);
    prog(off + 7'h06, 8'h3C);
    dbg_access_i <= 1'b1;
    wr(`FPUC_OFF_DBG, {24'h0, `FPUC_CMD_MASS});
    dbg_access_i <= 1'b0;
    settle;
    for (i = 0; i < 8; i = i + 1) fpuc_flash_ref_i.ers(i[2:0], 1'b1, 1'b1);
    vfy({pg, off + 7'h06});
    close_out;
  end
endmodule // flash_protect_unlock_ctrl_tb
